// File: src/cff_consts.vh
// Constants for the clocked FIFO read/write control block
`ifndef CFF_CONSTS_VH
`define CFF_CONSTS_VH
`define CFF_WIDTH 5
`define CFF_DEPTH 1024
`define CFF_AW 10
`define CFF_PW 11
`define CFF_STAGE_DEPTH 8
`define CFF_STAGE_AW 3
`define CFF_HOLD_RESET 5'h00
`define CFF_RSS_NS 12
`define CFF_CLK_NS 4
`define CFF_RSS_CYC ((`CFF_RSS_NS + `CFF_CLK_NS - 1) / `CFF_CLK_NS)
`define CFF_MODE_MASTER 1'b1
`define CFF_MODE_SLAVE 1'b0
`endif

// File: src/cff_stage_fifo.v
// Small valid/ready FIFO that buffers write-side words before the main array
`default_nettype none
module cff_stage_fifo #(
  parameter WIDTH = 5,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0] wptr_reg;
  reg [AW:0] rptr_reg;
  wire full;
  wire empty;
  wire push;
  wire pop;
  assign empty = (wptr_reg == rptr_reg);
  assign full = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) && (wptr_reg[AW] != rptr_reg[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;
  assign out_data = mem_reg[rptr_reg[AW-1:0]];
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wptr_reg <= {(AW+1){1'b0}};
      rptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/cff_fifo_ctrl.v
// Clocked FIFO of 1024 x 5 with master and slave read/write gating
`include "cff_consts.vh"
`default_nettype none
// Contract
// - Read when enabled and not empty
// - Empty flag updates only on read edges
// - Empty at read edge inhibits, outputs float
// - Primary read low holds previous word
// - Empty or secondary low floats outputs
// - Write when enabled and not full
// - Full flag updates only on write edges
// - Master write while full is discarded; slave write overwrites
// - Full flag reflects concurrent reads
// - Empty flag ignores concurrent writes
// - Reset clears full, sets empty, floats outputs
// - Array holds 1024 words of 5 bits
// - Full and empty flags active low
module cff_fifo_ctrl (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Variant select, high for master
  input wire master_mode,
  // Asynchronous master reset pin
  input wire master_reset_n,
  // Write side
  input wire write_clock,
  input wire write_enable_primary,
  input wire write_enable_secondary,
  input wire [`CFF_WIDTH-1:0] write_data,
  output wire write_stall,
  // Read side
  input wire read_clock,
  input wire read_enable_primary,
  input wire read_enable_secondary,
  output reg [`CFF_WIDTH-1:0] read_data,
  output reg read_data_oe_n,
  // Flags
  output reg full_flag_n,
  output reg empty_flag_n
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  // Pins are sampled twice before use; the pin clocks become edge events on mclk
  localparam NSYNC = 7 + `CFF_WIDTH;
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] pin_s1_reg;
  reg [NSYNC-1:0] pin_s2_reg;
  reg wclk_d_reg;
  reg rclk_d_reg;
  assign pin_raw = {write_data, master_reset_n, write_clock, read_clock, write_enable_primary,
                    write_enable_secondary, read_enable_primary, read_enable_secondary};
  always @(posedge mclk) begin
    if (rst) begin
      pin_s1_reg <= {NSYNC{1'b0}};
      pin_s2_reg <= {NSYNC{1'b0}};
      wclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      wclk_d_reg <= pin_s2_reg[5];
      rclk_d_reg <= pin_s2_reg[4];
    end
  end
  wire [`CFF_WIDTH-1:0] wdata_s;
  wire mrst_n_s;
  wire wclk_s;
  wire rclk_s;
  wire we1_s;
  wire we2_s;
  wire re1_s;
  wire re2_s;
  assign wdata_s = pin_s2_reg[NSYNC-1:7];
  assign mrst_n_s = pin_s2_reg[6];
  assign wclk_s = pin_s2_reg[5];
  assign rclk_s = pin_s2_reg[4];
  assign we1_s = pin_s2_reg[3];
  assign we2_s = pin_s2_reg[2];
  assign re1_s = pin_s2_reg[1];
  assign re2_s = pin_s2_reg[0];
  wire wedge;
  wire redge;
  wire clr;
  assign wedge = wclk_s & ~wclk_d_reg;
  assign redge = rclk_s & ~rclk_d_reg;
  // Reset pin acts once synchronised, without waiting for a pin clock edge
  assign clr = rst | ~mrst_n_s;
  // ****************************************
  // Write staging
  // ****************************************
  reg [`CFF_PW-1:0] wptr_reg;
  reg [`CFF_PW-1:0] rptr_reg;
  reg [`CFF_WIDTH-1:0] mem_reg [0:`CFF_DEPTH-1];
  wire occ_full;
  wire occ_empty;
  wire wr_go;
  wire st_in_valid;
  wire st_in_ready;
  wire st_out_valid;
  wire [`CFF_WIDTH-1:0] st_out_data;
  wire st_pop;
  // Master is gated by its latched flag, slave by its secondary enable only
  assign wr_go = wedge & we1_s & (master_mode ? full_flag_n : we2_s);
  assign st_in_valid = wr_go & ~clr;
  // A word offered while the stage is full is dropped; stall tells the producer
  assign write_stall = ~st_in_ready;
  assign occ_full = (wptr_reg[`CFF_AW-1:0] == rptr_reg[`CFF_AW-1:0]) &&
                    (wptr_reg[`CFF_AW] != rptr_reg[`CFF_AW]);
  assign occ_empty = (wptr_reg == rptr_reg);
  // Slave may overwrite when full; master holds staged words while the array is full
  assign st_pop = st_out_valid & (~occ_full | ~master_mode) & ~clr;
  cff_stage_fifo #(
    .WIDTH(`CFF_WIDTH),
    .DEPTH(`CFF_STAGE_DEPTH),
    .AW(`CFF_STAGE_AW)
  ) u_stage (
    .clk(mclk),
    .rst(clr),
    .in_valid(st_in_valid),
    .in_ready(st_in_ready),
    .in_data(wdata_s),
    .out_valid(st_out_valid),
    .out_ready(st_pop),
    .out_data(st_out_data)
  );
  // ****************************************
  // Storage array
  // ****************************************
  always @(posedge mclk) begin
    if (st_pop) begin
      mem_reg[wptr_reg[`CFF_AW-1:0]] <= st_out_data;
    end
  end
  // ****************************************
  // Read gating
  // ****************************************
  wire gate_ok;
  wire rd_go;
  wire hold_go;
  assign gate_ok = master_mode ? empty_flag_n : re2_s;
  assign rd_go = redge & gate_ok & re1_s;
  assign hold_go = redge & gate_ok & ~re1_s;
  // ****************************************
  // Pointers, flags and outputs
  // ****************************************
  // Full flag count adds one for a nonempty stage and the current write; wcount itself excludes staged words
  wire [`CFF_PW-1:0] wcount;
  wire [`CFF_PW-1:0] rd_inc;
  wire [`CFF_PW-1:0] st_cnt;
  assign rd_inc = {{(`CFF_PW-1){1'b0}}, rd_go};
  assign st_cnt = {{(`CFF_PW-1){1'b0}}, st_out_valid};
  assign wcount = wptr_reg - rptr_reg - rd_inc;
  always @(posedge mclk) begin
    if (clr) begin
      wptr_reg <= {`CFF_PW{1'b0}};
      rptr_reg <= {`CFF_PW{1'b0}};
      full_flag_n <= 1'b1;
      empty_flag_n <= 1'b0;
      read_data <= `CFF_HOLD_RESET;
      read_data_oe_n <= 1'b1;
    end else begin
      if (st_pop) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (rd_go) begin
        rptr_reg <= rptr_reg + 1'b1;
        read_data <= mem_reg[rptr_reg[`CFF_AW-1:0]];
        read_data_oe_n <= 1'b0;
      end else if (hold_go) begin
        read_data_oe_n <= 1'b0;
      end else if (redge) begin
        read_data_oe_n <= 1'b1;
      end
      // Flags latch only on their own clock edge, seeing the other side's progress
      if (wedge) begin
        full_flag_n <= ~((wcount + st_cnt + {{(`CFF_PW-1){1'b0}}, wr_go}) >=
                         `CFF_DEPTH);
      end
      if (redge) begin
        empty_flag_n <= ~(occ_empty | (rd_go & (wcount == {`CFF_PW{1'b0}})));
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/cff_checker.sv
// Port checker for the clocked FIFO control block
`default_nettype none
module cff_checker (
  input wire logic mclk, rst, master_mode, master_reset_n, write_clock, read_clock, read_enable_primary,
  input wire logic read_enable_secondary, read_data_oe_n, full_flag_n, empty_flag_n,
  input wire logic [4:0] read_data
);
  logic [3:0] ws, rs;
  wire logic gate = master_mode ? empty_flag_n : read_enable_secondary;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Cycles since a pin edge; a master reset also restarts them since it moves every output
  always_ff @(posedge mclk) begin
    ws <= (rst || !master_reset_n || $rose(write_clock)) ? 4'h0 : ws + {3'h0, ws != 4'hf};
    rs <= (rst || !master_reset_n || $rose(read_clock)) ? 4'h0 : rs + {3'h0, rs != 4'hf};
  end
  property p_fl; $changed(full_flag_n) |-> ws < 4'h6; endproperty
  a_fl: assert property (p_fl) else $error("full flag moved");
  property p_el; $changed(empty_flag_n) |-> rs < 4'h6; endproperty
  a_el: assert property (p_el) else $error("empty flag moved");
  property p_ql; $changed({read_data_oe_n, read_data}) |-> rs < 4'h6; endproperty
  a_ql: assert property (p_ql) else $error("output moved");
  property p_go; $rose(read_clock) && gate |-> ##[2:5] !read_data_oe_n; endproperty
  a_go: assert property (p_go) else $error("gated read floated");
  property p_ez; master_mode && !empty_flag_n && $rose(read_clock) |-> ##[2:5] read_data_oe_n; endproperty
  a_ez: assert property (p_ez) else $error("read while empty drove");
  property p_sz; !master_mode && !read_enable_secondary && $rose(read_clock) |-> ##[2:5] read_data_oe_n; endproperty
  a_sz: assert property (p_sz) else $error("slave drove");
  property p_hd; $rose(read_clock) && gate && !read_enable_primary && !read_data_oe_n |-> $stable(read_data) [*6];
  endproperty
  a_hd: assert property (p_hd) else $error("hold changed word");
  property p_mr; !master_reset_n [*5] |-> full_flag_n && !empty_flag_n && read_data_oe_n; endproperty
  a_mr: assert property (p_mr) else $error("bad reset state");
  c_hd: cover property ($rose(read_clock) && gate && !read_enable_primary);
  c_fl: cover property ($fell(full_flag_n));
  c_el: cover property ($fell(empty_flag_n));
endmodule
bind cff_fifo_ctrl cff_checker chk (.*);
`default_nettype wire

// File: testbench/cff_partner.sv
// Producer and consumer model on the write and read pins
`default_nettype none
module cff_partner (
  input wire logic mclk,
  output var logic [1:0] ck, e1, e2,
  output var logic [4:0] wd
);
  initial {ck, e1, e2, wd} = {2'h0, 2'h0, 2'h3, 5'h00};
  // Index 0 is the write side, 1 the read side; pin clock high 3 cycles, then low at least 7 before the next rise
  task automatic pin(input int r, input logic a, b, input logic [4:0] d);
    @(negedge mclk);
    e1[r] = a;
    e2[r] = b;
    if (r == 0) wd = d;
    repeat (3) @(negedge mclk);
    ck[r] = 1'b1;
    repeat (3) @(negedge mclk);
    ck[r] = 1'b0;
    repeat (3) @(negedge mclk);
    e1[r] = 1'b0;
    if (r == 0) wd = ~d;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_clocked_fifo_rw_control.sv
// Self-checking bench for the clocked FIFO control block
`default_nettype none
module test_clocked_fifo_rw_control;
  timeunit 1ns / 1ps;
  logic mclk = 1'b0, rst, master_mode, master_reset_n = 1'b1, read_data_oe_n, full_flag_n, empty_flag_n;
  logic [1:0] ck, e1, e2;
  logic [4:0] wd, read_data;
  logic write_stall;
  int failures = 0, comparisons = 0;
  always #2 mclk = ~mclk;
  cff_partner p (.mclk, .ck, .e1, .e2, .wd);
  cff_fifo_ctrl dut (.mclk, .rst, .master_mode, .master_reset_n, .write_clock(ck[0]), .read_clock(ck[1]),
    .write_enable_primary(e1[0]), .read_enable_primary(e1[1]), .write_enable_secondary(e2[0]),
    .read_enable_secondary(e2[1]), .write_data(wd), .write_stall, .read_data, .read_data_oe_n, .full_flag_n,
    .empty_flag_n);
  task check(input logic [5:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Mode only moves while reset is held
  task do_reset(input logic m);
    rst = 1'b1;
    master_mode = m;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
  endtask
  task flags(input logic [2:0] f);
    check({3'h0, full_flag_n, empty_flag_n, read_data_oe_n}, {3'h0, f});
  endtask
  // Floating outputs carry no word, so only the enable is compared then
  task rd(input logic a, b, input logic [5:0] exp);
    p.pin(1, a, b, 5'h00);
    check({read_data_oe_n, exp[5] ? 5'h00 : read_data}, exp);
  endtask
  task t_slave;
    do_reset(1'b0);
    rd(1'b0, 1'b1, 6'h00);
    rd(1'b1, 1'b0, 6'h20);
    // Secondary low must block the write, so the first read sees the second word
    p.pin(0, 1'b1, 1'b0, 5'h0c);
    p.pin(0, 1'b1, 1'b1, 5'h13);
    rd(1'b1, 1'b1, 6'h13);
  endtask
  task t_master;
    do_reset(1'b1);
    flags(3'h5);
    p.pin(0, 1'b1, 1'b1, 5'h15);
    p.pin(0, 1'b1, 1'b1, 5'h0a);
    check({5'h00, write_stall}, 6'h00);
    rd(1'b1, 1'b1, 6'h20);
    rd(1'b1, 1'b1, 6'h15);
    rd(1'b0, 1'b1, 6'h15);
    master_reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    flags(3'h5);
    master_reset_n = 1'b1;
    rd(1'b1, 1'b1, 6'h20);
  endtask
  task t_full;
    do_reset(1'b1);
    for (int i = 0; i < 1024; i++) p.pin(0, 1'b1, 1'b1, i[4:0]);
    flags(3'h1);
    p.pin(0, 1'b1, 1'b1, 5'h1b);
    rd(1'b1, 1'b1, 6'h20);
    rd(1'b1, 1'b1, 6'h00);
    flags(3'h2);
    p.pin(0, 1'b0, 1'b1, 5'h00);
    flags(3'h6);
    for (int i = 1; i < 1024; i++) rd(1'b1, 1'b1, {1'b0, i[4:0]});
    rd(1'b1, 1'b1, 6'h20);
  endtask
  initial begin
    t_slave;
    t_master;
    t_full;
    print_verdict;
  end
endmodule
`default_nettype wire
